// [logic/qpms_sequencer.sv]
// Purpose: sequences temperature and pressure period measurements into result records
// Assumes: host commands arrive as one-cycle strobes from a command decoder
// Notes: compensation arithmetic lives downstream; records carry cycles and edge counts
// Behaviour
// - each period is found by counting the signal over a gate, longer gate finer.
// - gate programmable from 0.02 s to 131.06 s in 0.02 s steps.
// - pressure and temperature gates are separate, independently writable settings.
// - pressure: measure temperature, derive it, measure pressure, compute, then output.
// - temperature reading: measure temperature period only, derive, then output.
// - period reading: measure chosen signal, output raw period, no compensation.
// - raw period results leave only through the serial record output.
// - single mode yields exactly one result per single request.
// - continuous mode repeats results back to back until the host stops it.
// - fast continuous mode measures temperature only occasionally, mostly pressure.
// - sample and hold keeps the result until a separate read request.
// - with tare on, stored tare is subtracted; loadable from pressure or host.
// - records carry a tare marker while tare is in effect.
// - output stalls limit rate only, never change gate length or resolution.
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module qpms_sequencer import qpms_pkg::*; #(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
  input wire logic core_clk_i,  // core clock, 125 MHz
  input wire logic rstn_i,  // async reset, active low
  input wire logic press_sig_i,  // pressure square wave
  input wire logic temp_sig_i,  // temperature square wave
  input wire qpms_cmd_t cmd_i,  // command strobes
  input wire qpms_meas_t cmd_type_i,  // measurement type with a strobe
  input wire logic wb_cyc_i,  // wishbone cycle
  input wire logic wb_stb_i,  // wishbone strobe
  input wire logic wb_we_i,  // wishbone write
  input wire logic [ADDR_W-1:0] wb_adr_i,  // wishbone byte address
  input wire logic [3:0] wb_sel_i,  // wishbone byte selects
  input wire logic [31:0] wb_dat_i,  // wishbone write data
  output logic [31:0] wb_dat_o,  // wishbone read data
  output logic wb_ack_o,  // wishbone acknowledge
  output qpms_rec_t rec_o,  // result record to serial formatter
  output logic rec_valid_o,  // record available
  input wire logic rec_ready_i  // serial path takes record
);
  typedef enum logic [2:0] {S_IDLE, S_TMEAS, S_TCALC, S_PMEAS, S_PCALC, S_EMIT} qpms_state_t;
  qpms_state_t state;
  qpms_mode_t mode;
  qpms_meas_t mtype;
  qpms_rec_t rec, held;
  logic held_valid;
  logic tare_en;
  logic [HS_W-1:0] hs_every, hs_cnt;
  logic [WIN_W-1:0] p_win, t_win;
  logic [31:0] tare_val, t_ofs;
  logic [CNT_W-1:0] press_raw;
  logic t_start, p_start, t_done, p_done, abort;
  logic [CNT_W-1:0] t_cycles, p_cycles;
  logic [EDGE_W-1:0] t_edges, p_edges;
  logic buf_ready, push;
  logic wb_req, wb_wr;
  logic start_any, start_fast, busy;
  qpms_meas_t start_type;
  logic [31:0] rd_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // two identical counters keep the two gates fully independent
  qpms_period_counter #(.STEP_CYCLES(STEP_CYCLES)) u_tcnt (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sig_i(temp_sig_i),
    .start_i(t_start),
    .abort_i(abort),
    .steps_i(t_win),
    .done_o(t_done),
    .cycles_o(t_cycles),
    .edges_o(t_edges)
  );
  qpms_period_counter #(.STEP_CYCLES(STEP_CYCLES)) u_pcnt (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .sig_i(press_sig_i),
    .start_i(p_start),
    .abort_i(abort),
    .steps_i(p_win),
    .done_o(p_done),
    .cycles_o(p_cycles),
    .edges_o(p_edges)
  );

  // records only leave here, through the buffer, to the serial formatter
  qpms_buf2 #(.WIDTH($bits(qpms_rec_t))) u_buf (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(state == S_EMIT && mode != MD_HOLD),
    .in_ready_o(buf_ready),
    .in_data_i(rec),
    .out_valid_o(rec_valid_o),
    .out_ready_i(rec_ready_i),
    .out_data_o(rec_o)
  );

  assign busy = (state != S_IDLE);
  assign push = (state == S_EMIT) && (mode != MD_HOLD) && buf_ready;
  assign abort = cmd_i.stop;
  assign start_any = (state == S_IDLE) && (cmd_i.single | cmd_i.cont | cmd_i.fast |
                     cmd_i.trigger);
  assign start_type = cmd_i.fast ? MT_PRESS : cmd_type_i;
  // next cycle of a running fast continuous sequence
  assign start_fast = (mode == MD_FAST) && push && !cmd_i.stop;

  // measurement sequence
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= S_IDLE;
      mode <= MD_SINGLE;
      mtype <= MT_PRESS;
      t_start <= 1'b0;
      p_start <= 1'b0;
      hs_cnt <= '0;
    end else begin
      t_start <= 1'b0;
      p_start <= 1'b0;
      if (cmd_i.stop) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            if (start_any) begin
              mtype <= start_type;
              mode <= cmd_i.fast ? MD_FAST : cmd_i.cont ? MD_CONT :
                      cmd_i.trigger ? MD_HOLD : MD_SINGLE;
              hs_cnt <= '0;
              if (start_type == MT_PPER) begin
                state <= S_PMEAS;
                p_start <= 1'b1;
              end else begin
                state <= S_TMEAS;
                t_start <= 1'b1;
              end
            end else if (cmd_i.read_held && held_valid) begin
              mode <= MD_SINGLE;
              state <= S_EMIT;
            end
          end
          S_TMEAS: begin
            if (t_done) begin
              state <= (mtype == MT_TPER) ? S_EMIT : S_TCALC;
            end
          end
          S_TCALC: begin
            if (mtype == MT_PRESS) begin
              state <= S_PMEAS;
              p_start <= 1'b1;
            end else begin
              state <= S_EMIT;
            end
          end
          S_PMEAS: begin
            if (p_done) begin
              state <= (mtype == MT_PPER) ? S_EMIT : S_PCALC;
            end
          end
          S_PCALC: state <= S_EMIT;
          S_EMIT: begin
            if (mode == MD_HOLD) begin
              state <= S_IDLE;
            end else if (push) begin
              if (mode == MD_CONT) begin
                if (mtype == MT_PPER) begin
                  state <= S_PMEAS;
                  p_start <= 1'b1;
                end else begin
                  state <= S_TMEAS;
                  t_start <= 1'b1;
                end
              end else if (mode == MD_FAST) begin
                if (hs_cnt == '0) begin
                  hs_cnt <= hs_every;
                  state <= S_TMEAS;
                  t_start <= 1'b1;
                end else begin
                  hs_cnt <= hs_cnt - 1'b1;
                  state <= S_PMEAS;
                  p_start <= 1'b1;
                end
              end else begin
                state <= S_IDLE;
              end
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // derived values and the outgoing record
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rec <= '0;
      press_raw <= '0;
    end else begin
      if (state == S_IDLE && cmd_i.read_held && held_valid && !start_any) begin
        rec <= held;
      end
      if (state == S_TMEAS && t_done) begin
        rec <= '{kind: mtype, tare_mark: tare_en, value: t_cycles, edges: t_edges};
      end
      if (state == S_TCALC) begin
        rec.value <= rec.value - CNT_W'(t_ofs);
      end
      if (state == S_PMEAS && p_done) begin
        press_raw <= p_cycles;
        rec <= '{kind: mtype, tare_mark: tare_en, value: p_cycles, edges: p_edges};
      end
      if (state == S_PCALC) begin
        rec.value <= tare_en ? press_raw - CNT_W'(tare_val) : press_raw;
        rec.tare_mark <= tare_en;
      end
    end
  end

  // held result for sample and hold; set and clear never meet in one state
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      held <= '0;
      held_valid <= 1'b0;
    end else begin
      if (state == S_EMIT && mode == MD_HOLD) begin
        held <= rec;
        held_valid <= 1'b1;
      end else if (state == S_IDLE && cmd_i.read_held && !start_any) begin
        held_valid <= 1'b0;
      end
    end
  end

  // wishbone slave, one wait state, unmapped reads return zero
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  always_comb begin
    rd_data = '0;
    case (wb_adr_i)
      REG_CTRL: begin
        rd_data[CTRL_TARE_BIT] = tare_en;
        rd_data[CTRL_HS_LSB +: HS_W] = hs_every;
      end
      REG_PWIN: rd_data[WIN_W-1:0] = p_win;
      REG_TWIN: rd_data[WIN_W-1:0] = t_win;
      REG_TARE: rd_data = tare_val;
      REG_STAT: begin
        rd_data[STAT_BUSY_BIT] = busy;
        rd_data[STAT_HELD_BIT] = held_valid;
        rd_data[STAT_MODE_LSB +: 2] = mode;
        rd_data[STAT_TARE_BIT] = tare_en;
      end
      REG_TOFS: rd_data = t_ofs;
      default: rd_data = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= rd_data;
    end
  end

  // settings; each window is clamped into its legal step range
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tare_en <= 1'b0;
      hs_every <= HS_RST;
      p_win <= WIN_RST;
      t_win <= WIN_RST;
      tare_val <= '0;
      t_ofs <= '0;
    end else begin
      if (wb_wr && wb_adr_i == REG_CTRL) begin
        if (wb_sel_i[0]) begin
          tare_en <= wb_dat_i[CTRL_TARE_BIT];
        end
        if (wb_sel_i[1]) begin
          hs_every <= wb_dat_i[CTRL_HS_LSB +: HS_W];
        end
      end
      if (wb_wr && wb_adr_i == REG_PWIN) begin
        p_win <= clamp(merge({19'h0, p_win}, wb_dat_i, wb_sel_i));
      end
      if (wb_wr && wb_adr_i == REG_TWIN) begin
        t_win <= clamp(merge({19'h0, t_win}, wb_dat_i, wb_sel_i));
      end
      if (cmd_i.tare_capture) begin
        tare_val <= press_raw[31:0];
      end else if (wb_wr && wb_adr_i == REG_TARE) begin
        tare_val <= merge(tare_val, wb_dat_i, wb_sel_i);
      end
      if (wb_wr && wb_adr_i == REG_TOFS) begin
        t_ofs <= merge(t_ofs, wb_dat_i, wb_sel_i);
      end
    end
  end

  function automatic logic [WIN_W-1:0] clamp(input logic [31:0] v);
    if (v < 32'(WIN_MIN)) begin
      return WIN_MIN;
    end
    if (v > 32'(WIN_MAX)) begin
      return WIN_MAX;
    end
    return v[WIN_W-1:0];
  endfunction

  a_single_once: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (push && mode == MD_SINGLE && !cmd_i.stop) |=> state == S_IDLE ##1 !push)
    else $error("single request produced more than one result");
  a_cont_repeat: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (push && mode == MD_CONT && !cmd_i.stop) |=> (state == S_TMEAS || state == S_PMEAS))
    else $error("continuous mode stopped without a stop request");
  a_press_order: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_TCALC && mtype == MT_PRESS && !cmd_i.stop) |=> state == S_PMEAS && p_start)
    else $error("pressure period not measured after temperature");
  a_temp_only: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_TMEAS && t_done && mtype == MT_TEMP && !cmd_i.stop)
      |=> state == S_TCALC ##1 (state == S_EMIT || $past(cmd_i.stop)))
    else $error("temperature reading took a wrong path");
  a_raw_period: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (push && rec.kind == MT_PPER && mode != MD_SINGLE) |-> rec.value == press_raw)
    else $error("pressure period record was altered");
  a_tare_sub: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_PCALC && tare_en && !cmd_i.stop)
      |=> rec.value == $past(press_raw) - CNT_W'($past(tare_val)))
    else $error("tare not subtracted from pressure");
  a_tare_mark: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_PCALC && !cmd_i.stop) |=> rec.tare_mark == $past(tare_en))
    else $error("tare marker does not follow tare state");
  a_hold_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_EMIT && mode == MD_HOLD) |-> !push ##1 held_valid)
    else $error("held result was output without a read request");
  a_fast_skip: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (start_fast && hs_cnt != '0) |=> state == S_PMEAS && hs_cnt == $past(hs_cnt) - 1'b1)
    else $error("fast mode measured temperature too often");
  a_stall_gate: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == S_EMIT && !buf_ready && mode != MD_HOLD && !cmd_i.stop) |=> state == S_EMIT)
    else $error("record dropped under output stall");
endmodule

// [logic/qpms_pkg.sv]
// Purpose: shared constants and types of the quartz period measurement sequencer
// Assumes: 125 MHz core clock, classic Wishbone register bus with 32-bit data
// Notes: window settings count 20 ms steps
package qpms_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned STEP_MS = 20;
  localparam int unsigned STEP_CYCLES_DEF = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned WIN_W = 13;
  localparam logic [WIN_W-1:0] WIN_MIN = 13'h0001;
  localparam logic [WIN_W-1:0] WIN_MAX = 13'h1999;
  localparam logic [WIN_W-1:0] WIN_RST = 13'h0032;
  localparam int unsigned CNT_W = 40;
  localparam int unsigned EDGE_W = 24;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PWIN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TWIN = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TARE = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] REG_TOFS = 8'h14;
  localparam int unsigned CTRL_TARE_BIT = 0;
  localparam int unsigned CTRL_HS_LSB = 8;
  localparam int unsigned HS_W = 8;
  localparam logic [HS_W-1:0] HS_RST = 8'h10;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_HELD_BIT = 1;
  localparam int unsigned STAT_MODE_LSB = 2;
  localparam int unsigned STAT_TARE_BIT = 4;

  typedef enum logic [1:0] {MT_PRESS, MT_TEMP, MT_PPER, MT_TPER} qpms_meas_t;
  typedef enum logic [1:0] {MD_SINGLE, MD_CONT, MD_FAST, MD_HOLD} qpms_mode_t;

  typedef struct packed {
    qpms_meas_t kind;
    logic tare_mark;
    logic [CNT_W-1:0] value;
    logic [EDGE_W-1:0] edges;
  } qpms_rec_t;

  typedef struct packed {
    logic single;
    logic cont;
    logic fast;
    logic stop;
    logic trigger;
    logic read_held;
    logic tare_capture;
  } qpms_cmd_t;
endpackage

// [logic/qpms_period_counter.sv]
// Purpose: reciprocal period counter over a gate of whole input periods
// Assumes: sig_i is asynchronous to core_clk_i
// Notes: period = cycles_o / edges_o; a longer gate gives finer resolution
`timescale 1ns/1ps
module qpms_period_counter import qpms_pkg::*; #(
  parameter int unsigned STEP_CYCLES = STEP_CYCLES_DEF
) (
  input wire logic core_clk_i,  // core clock
  input wire logic rstn_i,  // async reset, active low
  input wire logic sig_i,  // transducer square wave
  input wire logic start_i,  // start one measurement
  input wire logic abort_i,  // abandon the measurement
  input wire logic [WIN_W-1:0] steps_i,  // gate length in 20 ms steps
  output logic done_o,  // result ready pulse
  output logic [CNT_W-1:0] cycles_o,  // clock cycles over the gate
  output logic [EDGE_W-1:0] edges_o  // input periods over the gate
);
  typedef enum logic [1:0] {C_IDLE, C_ARM, C_GATE, C_CLOSE} qpms_cstate_t;
  qpms_cstate_t state;
  logic s1, s2, s3;
  logic rise;
  logic [31:0] div;
  logic step_tick;
  logic [WIN_W-1:0] step_cnt, eff;
  logic [CNT_W-1:0] cyc;
  logic [EDGE_W-1:0] edg;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= sig_i;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign rise = s2 & ~s3;
  assign eff = (steps_i < WIN_MIN) ? WIN_MIN : steps_i;
  assign step_tick = (div == STEP_CYCLES - 1);

  // gate opens and closes on input edges so only whole periods are counted
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state <= C_IDLE;
      div <= '0;
      step_cnt <= '0;
      cyc <= '0;
      edg <= '0;
      done_o <= 1'b0;
      cycles_o <= '0;
      edges_o <= '0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        state <= C_IDLE;
      end else begin
        case (state)
          C_IDLE: begin
            if (start_i) begin
              state <= C_ARM;
            end
          end
          C_ARM: begin
            if (rise) begin
              state <= C_GATE;
              div <= '0;
              step_cnt <= '0;
              cyc <= '0;
              edg <= '0;
            end
          end
          C_GATE: begin
            cyc <= cyc + 1'b1;
            if (rise) begin
              edg <= edg + 1'b1;
            end
            div <= step_tick ? '0 : div + 1'b1;
            if (step_tick) begin
              step_cnt <= step_cnt + 1'b1;
              if (step_cnt == eff - 1'b1) begin
                state <= C_CLOSE;
              end
            end
          end
          C_CLOSE: begin
            if (rise) begin
              state <= C_IDLE;
              done_o <= 1'b1;
              cycles_o <= cyc + 1'b1;
              edges_o <= edg + 1'b1;
            end else begin
              cyc <= cyc + 1'b1;
            end
          end
          default: state <= C_IDLE;
        endcase
      end
    end
  end

  a_gate_length: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      (state == C_GATE && !abort_i && step_tick && step_cnt == eff - 1'b1)
      |=> state == C_CLOSE)
    else $error("gate did not close after the programmed steps");
  a_result_edges: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      done_o |-> (edges_o != '0 && cycles_o >= CNT_W'(STEP_CYCLES)))
    else $error("result spans no whole period or too short a gate");
endmodule

// [logic/qpms_buf2.sv]
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock
// Notes: in_ready_o falls only when both entries hold a word
`timescale 1ns/1ps
module qpms_buf2 import qpms_pkg::*; #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic core_clk_i,  // core clock
  input wire logic rstn_i,  // async reset, active low
  input wire logic in_valid_i,  // word offered
  output logic in_ready_o,  // room for a word
  input wire logic [WIDTH-1:0] in_data_i,  // word in
  output logic out_valid_o,  // word available
  input wire logic out_ready_i,  // receiver takes word
  output logic [WIDTH-1:0] out_data_o  // word out
);
  logic [WIDTH-1:0] mem [2];
  logic rd_ptr, wr_ptr;
  logic [1:0] count;
  logic push, pop;

  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem[0] <= '0;
      mem[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// [test/qpms_xducer_model.sv]
// Purpose: transducer stand-in giving the pressure and temperature square waves
// Assumes: half periods are whole nanoseconds, 7 and 10 core cycles per period
// Notes: the waves run free, as a quartz oscillator does
`timescale 1ns/1ps
module qpms_xducer_model #(
  parameter int P_HALF = 28,
  parameter int T_HALF = 40,
  parameter int P_OFS = 2
) (
  output logic press_sig_o,  // pressure wave
  output logic temp_sig_o  // temperature wave
);
  initial begin
    temp_sig_o = 1'b0;
    forever #(T_HALF) temp_sig_o = ~temp_sig_o;
  end
  // pressure edges kept off the rising clock edges so the first flop never races them
  initial begin
    press_sig_o = 1'b0;
    #(P_OFS);
    forever #(P_HALF) press_sig_o = ~press_sig_o;
  end
endmodule

// [test/qpms_sequencer_bench.sv]
// Purpose: self-checking bench of the period measurement sequencer
// Assumes: short gate steps of 10 cycles, pressure 7 and temperature 10 cycles a period
// Notes: period is checked as value over edges, rounded
`timescale 1ns/1ps
module qpms_sequencer_bench import qpms_pkg::*; ;
  localparam int SC = 10;
  localparam qpms_cmd_t C_SGL = 7'h40;
  localparam qpms_cmd_t C_CONT = 7'h20;
  localparam qpms_cmd_t C_FAST = 7'h10;
  localparam qpms_cmd_t C_STOP = 7'h08;
  localparam qpms_cmd_t C_TRIG = 7'h04;
  localparam qpms_cmd_t C_READ = 7'h02;
  localparam qpms_cmd_t C_TCAP = 7'h01;
  logic clk, rstn, psig, tsig, cyc, stb, we, ack, vld, rdy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  qpms_cmd_t cmd;
  qpms_meas_t typ;
  qpms_rec_t rec, r;
  int bad_count, n_tests, seed, pw, tare;

  qpms_sequencer #(.STEP_CYCLES(SC)) DUT (.core_clk_i(clk), .rstn_i(rstn), .press_sig_i(psig),
    .temp_sig_i(tsig), .cmd_i(cmd), .cmd_type_i(typ), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .rec_o(rec), .rec_valid_o(vld), .rec_ready_i(rdy));
  qpms_xducer_model XDCR (.press_sig_o(psig), .temp_sig_o(tsig));

  always #4 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1 && ++k < 20);
    q = rdat;
    if (ack !== 1'b1) bad_count++;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic go(input qpms_cmd_t c, input qpms_meas_t t);
    @(posedge clk);
    cmd <= c;
    typ <= t;
    @(posedge clk);
    cmd <= 7'h00;
  endtask

  // receiver stalls a random while before it takes a record
  task automatic take();
    int k;
    k = 0;
    repeat (1 + $unsigned($random(seed)) % 4) @(posedge clk);
    rdy <= 1'b1;
    do @(posedge clk); while (vld !== 1'b1 && ++k < 3000);
    r = rec;
    if (vld !== 1'b1) bad_count++;
    rdy <= 1'b0;
  endtask

  task automatic idle();
    int k;
    k = 0;
    do wb(1'b0, REG_STAT, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0 && ++k < 200);
    repeat (2) if (vld === 1'b1) take();
  endtask

  function automatic longint per(qpms_rec_t x, longint add);
    // undo the subtraction modulo the value width, as the hardware wraps
    return (longint'(CNT_W'(longint'(x.value) + add)) + longint'(x.edges) / 2) /
           longint'(x.edges);
  endfunction

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #400_000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {cyc, stb, we, rdy} = 4'h0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    cmd = 7'h00;
    typ = MT_PRESS;
    bad_count = 0;
    n_tests = 0;
    seed = 34;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, REG_PWIN, 32'h0);
    chk(q, 32'h32);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, REG_TWIN, 32'h0);
    wb(1'b0, REG_TWIN, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, REG_PWIN, 32'h1FFF);
    wb(1'b0, REG_PWIN, 32'h0);
    chk(q, 32'h1999);
    pw = 1 + $unsigned($random(seed)) % 4;
    wb(1'b1, REG_TWIN, 32'h4);
    wb(1'b1, REG_PWIN, pw);
    wb(1'b0, REG_TWIN, 32'h0);
    chk(q, 32'h4);
    // second strobe lands while busy and must be dropped
    go(C_SGL, MT_PPER);
    go(C_SGL, MT_PPER);
    take();
    chk(r.value >= pw * SC && r.value < pw * SC + 9, 1'b1);
    idle();
    chk(vld, 1'b0);
    wb(1'b1, REG_TOFS, 32'h7);
    for (int i = 0; i < 4; i++) begin
      go(C_SGL, qpms_meas_t'(i));
      take();
      chk(r.kind, i);
      chk(per(r, (i == 1) ? 7 : 0), i[0] ? 10 : 7);
      chk(r.tare_mark, 1'b0);
      idle();
    end
    tare = $unsigned($random(seed)) % 256;
    wb(1'b1, REG_TARE, tare);
    wb(1'b1, REG_CTRL, 32'h1001);
    go(C_SGL, MT_PRESS);
    take();
    chk(r.tare_mark, 1'b1);
    chk(per(r, tare), 7);
    go(C_TCAP, MT_PRESS);
    wb(1'b0, REG_TARE, 32'h0);
    chk(q, 32'(r.value + tare));
    wb(1'b1, REG_CTRL, 32'h1000);
    // long stall fills the buffer; periods must stay intact
    go(C_CONT, MT_PPER);
    repeat (400) @(posedge clk);
    repeat (3) begin
      take();
      chk(per(r, 0), 7);
    end
    go(C_STOP, MT_PRESS);
    idle();
    repeat (100) @(posedge clk);
    chk(vld, 1'b0);
    wb(1'b1, REG_CTRL, 32'h0200);
    go(C_FAST, MT_PRESS);
    repeat (4) begin
      take();
      chk(r.kind, MT_PRESS);
    end
    wb(1'b0, REG_STAT, 32'h0);
    chk(q[3:2], 2'h2);
    go(C_STOP, MT_PRESS);
    idle();
    go(C_TRIG, MT_TPER);
    idle();
    chk(q[STAT_HELD_BIT], 1'b1);
    chk(vld, 1'b0);
    go(C_READ, MT_TPER);
    take();
    chk(per(r, 0), 10);
    wb(1'b0, REG_STAT, 32'h0);
    chk(q[STAT_HELD_BIT], 1'b0);
    tally_and_finish();
  end
endmodule
